// ==== src/vfsr_pkg.sv ====
package vfsr_pkg;

    // ==========================================================
    // Status byte field positions
    localparam int BIT_PS_FAULT    = 7;
    localparam int BIT_SENSE_OPEN  = 6;
    localparam int BIT_PH_LIMIT    = 5;
    localparam int BIT_TEMP_LEVEL  = 4;
    localparam int BIT_VCODE_RST   = 3;
    localparam int BIT_SHARE_FAULT = 0;

    // Writable bits mask, bits 2 and 1 reserved
    localparam logic [7:0] STATUS_WMASK   = 8'hf9;
    localparam logic [7:0] STATUS_RESET   = 8'h00;

    // ==========================================================
    // Paging
    localparam logic [7:0] PAGE_CH_A   = 8'h00;
    localparam logic [7:0] PAGE_CH_B   = 8'h01;
    localparam logic [7:0] PAGE_ALL    = 8'hff;
    localparam logic [7:0] PAGE_RESET  = 8'h00;

    // ==========================================================
    // Phase counts
    localparam int          NUM_PHASES    = 4;
    localparam logic [2:0]  MAX_PHASES_A  = 3'h3;
    localparam logic [2:0]  MAX_PHASES_B  = 3'h1;

    // ==========================================================
    // Share fault detection
    localparam int          SHARE_CYCLES  = 7;
    localparam logic [2:0]  SHARE_CNT_MAX = 3'h7;

    // ==========================================================
    // Temperature sense threshold in millivolts
    localparam logic [11:0] TEMP_THRESH_MV = 12'h096;

    // ==========================================================
    // Address strap: 10 kohm strap code gives address 105 decimal
    localparam logic [3:0]  STRAP_CODE_10K = 4'h0;
    localparam logic [6:0]  ADDR_10K       = 7'h69;
    localparam logic [6:0]  ADDR_BASE      = 7'h60;

    // ==========================================================
    // Switching frequency defaults in kHz
    localparam logic [9:0]  FSW_DEF_A_KHZ  = 10'h190;
    localparam logic [9:0]  FSW_DEF_B_KHZ  = 10'h1c2;

endpackage

// ==== src/vfsr_share_det.sv ====
`timescale 1ns/10ps
module vfsr_share_det (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    // Detection cycle strobe and imbalance warning
    input  wire logic       i_det_tick,
    input  wire logic       i_imbalance,
    // Repetitive fault event
    output logic            o_fault
);

    typedef struct packed {
        logic [2:0] cnt;
        logic       fault;
    } vfsr_det_s;

    vfsr_det_s st_q;
    vfsr_det_s st_d;

    // Count consecutive detection cycles with warning
    always_comb begin
        st_d       = st_q;
        st_d.fault = 1'b0;
        if (i_det_tick) begin
            if (!i_imbalance) begin
                st_d.cnt = 3'h0;
            end else if (st_q.cnt == vfsr_pkg::SHARE_CNT_MAX - 3'h1) begin
                st_d.fault = 1'b1;
                st_d.cnt   = vfsr_pkg::SHARE_CNT_MAX - 3'h1;
            end else begin
                st_d.cnt = st_q.cnt + 3'h1;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_fault = st_q.fault;

endmodule

// ==== src/vfsr_top.sv ====
// How it works
// - Latch power stage fault in bit 7
// - Latch open sense pin at power-up
// - Clamp phase count, set bit 5 warning
// - Latch temperature sense level before soft-start
// - Bit 3 set on code reset, page 0
// - Seven consecutive imbalance cycles set bit 0
// - Separate read of per-phase imbalance warnings
// - Writing one clears bit, zero keeps
// - Bus address derived from strap pin
// - Default switching frequencies 400 and 450 kHz
// - Parameters stored as new power-up defaults
// - Paged, page FFh reads channel A
`timescale 1ns/10ps
module vfsr_top (
    // Clock and reset
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_reset,
    // Register access from the bus engine
    input  wire logic [7:0]                    i_page,
    input  wire logic                          i_status_wr,
    input  wire logic [7:0]                    i_status_wdata,
    input  wire logic                          i_status_rd,
    output logic [7:0]                         o_status_rdata,
    output logic [3:0]                         o_imbalance_rdata,
    // Fault and condition events, per channel except code reset, from analog pins
    input  wire logic [1:0]                    i_ps_fault,
    input  wire logic [1:0]                    i_sense_open,
    input  wire logic [1:0]                    i_temp_high,
    input  wire logic [1:0]                    i_soft_start,
    input  wire logic                          i_vcode_reset,
    // Phase share detection, per phase
    input  wire logic                          i_det_tick,
    input  wire logic [3:0]                    i_imbalance,
    // Phase count configuration
    input  wire logic [2:0]                    i_phase_cfg_a,
    input  wire logic [2:0]                    i_phase_cfg_b,
    output logic [2:0]                         o_phase_op_a,
    output logic [2:0]                         o_phase_op_b,
    // Address strap and defaults
    input  wire logic [3:0]                    i_addr_strap,
    output logic [6:0]                         o_bus_addr,
    // Parameter store
    input  wire logic                          i_param_wr,
    input  wire logic [9:0]                    i_fsw_a_khz,
    input  wire logic [9:0]                    i_fsw_b_khz,
    input  wire logic                          i_store_nvm,
    output logic [9:0]                         o_fsw_a_khz,
    output logic [9:0]                         o_fsw_b_khz
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [1:0][7:0] status;
        logic [2:0]      phase_a;
        logic [2:0]      phase_b;
        logic [6:0]      addr;
        logic [9:0]      fsw_a;
        logic [9:0]      fsw_b;
        logic [9:0]      nvm_a;
        logic [9:0]      nvm_b;
        logic            nvm_valid;
        logic            boot;
        logic [1:0]      ss_seen;
        logic [7:0]      rdata;
        logic [3:0]      imb_rd;
    } vfsr_st_s;

    // Input synchronisers for pins
    typedef struct packed {
        logic [1:0] ps;
        logic [1:0] so;
        logic [1:0] th;
        logic [1:0] ss;
        logic       vr;
        logic [3:0] imb;
        logic       tick;
        logic [3:0] strap;
    } vfsr_pin_s;

    vfsr_st_s  st_q;
    vfsr_st_s  st_d;
    vfsr_pin_s p1_q;
    vfsr_pin_s p2_q;
    logic      share_fault;
    logic [1:0] wr_ch;

    // ==========================================================
    // Two-stage pin synchroniser, free running so the strap is settled at boot
    always_ff @(posedge i_clk_sys) begin
        p1_q <= {i_ps_fault, i_sense_open, i_temp_high, i_soft_start,
                 i_vcode_reset, i_imbalance, i_det_tick, i_addr_strap};
        p2_q <= p1_q;
    end

    // ==========================================================
    // Share fault detector, any phase of channel A or channel B
    logic [3:0] ph_fault;
    genvar g;
    generate
        for (g = 0; g < vfsr_pkg::NUM_PHASES; g++) begin : g_ph
            vfsr_share_det u_det (
                .i_clk_sys   (i_clk_sys),
                .i_reset     (i_reset),
                .i_det_tick  (p2_q.tick),
                .i_imbalance (p2_q.imb[g]),
                .o_fault     (ph_fault[g])
            );
        end
    endgenerate

    // Phases 0..2 belong to channel A, phase 3 to channel B
    assign share_fault = |ph_fault[2:0];

    // Page decode for writes: FFh writes both channels
    always_comb begin
        wr_ch = 2'b00;
        if (i_status_wr) begin
            if (i_page == vfsr_pkg::PAGE_CH_A) begin
                wr_ch = 2'b01;
            end else if (i_page == vfsr_pkg::PAGE_CH_B) begin
                wr_ch = 2'b10;
            end else if (i_page == vfsr_pkg::PAGE_ALL) begin
                wr_ch = 2'b11;
            end
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] set_v;
        logic [7:0] clr_v;
        set_v = 8'h00;
        clr_v = 8'h00;
        st_d  = st_q;
        for (int c = 0; c < 2; c++) begin
            set_v = 8'h00;
            clr_v = 8'h00;
            set_v[vfsr_pkg::BIT_PS_FAULT] = p2_q.ps[c];
            // Sense pin sampled until soft-start
            if (!st_q.ss_seen[c]) begin
                set_v[vfsr_pkg::BIT_SENSE_OPEN] = p2_q.so[c];
                set_v[vfsr_pkg::BIT_TEMP_LEVEL] = p2_q.th[c];
            end
            if (c == 0) begin
                set_v[vfsr_pkg::BIT_PH_LIMIT]    = i_phase_cfg_a > vfsr_pkg::MAX_PHASES_A;
                set_v[vfsr_pkg::BIT_VCODE_RST]   = p2_q.vr;
                set_v[vfsr_pkg::BIT_SHARE_FAULT] = share_fault;
            end else begin
                set_v[vfsr_pkg::BIT_PH_LIMIT]    = i_phase_cfg_b > vfsr_pkg::MAX_PHASES_B;
                set_v[vfsr_pkg::BIT_SHARE_FAULT] = ph_fault[3];
            end
            if (wr_ch[c]) begin
                clr_v = i_status_wdata & vfsr_pkg::STATUS_WMASK;
            end
            // Set wins over clear; reserved bits forced low
            st_d.status[c] = ((st_q.status[c] & ~clr_v) | set_v)
                             & vfsr_pkg::STATUS_WMASK;
            if (st_q.boot) begin
                st_d.status[c] = vfsr_pkg::STATUS_RESET;
            end
        end
        // Level before soft-start is latched high when above threshold
        st_d.ss_seen = st_q.ss_seen | p2_q.ss;
        // Clamp operational phase count
        o_phase_op_a_calc: begin
            st_d.phase_a = (i_phase_cfg_a > vfsr_pkg::MAX_PHASES_A) ?
                           vfsr_pkg::MAX_PHASES_A : i_phase_cfg_a;
            st_d.phase_b = (i_phase_cfg_b > vfsr_pkg::MAX_PHASES_B) ?
                           vfsr_pkg::MAX_PHASES_B : i_phase_cfg_b;
        end
        // Address from strap, caught once after reset release
        if (st_q.boot) begin
            st_d.addr = (p2_q.strap == vfsr_pkg::STRAP_CODE_10K) ?
                        vfsr_pkg::ADDR_10K :
                        vfsr_pkg::ADDR_BASE + {3'h0, p2_q.strap};
            st_d.boot = 1'b0;
            if (st_q.nvm_valid) begin
                st_d.fsw_a = st_q.nvm_a;
                st_d.fsw_b = st_q.nvm_b;
            end
        end
        // Parameter write and store
        if (i_param_wr) begin
            st_d.fsw_a = i_fsw_a_khz;
            st_d.fsw_b = i_fsw_b_khz;
        end
        if (i_store_nvm) begin
            st_d.nvm_a     = st_q.fsw_a;
            st_d.nvm_b     = st_q.fsw_b;
            st_d.nvm_valid = 1'b1;
        end
        // Read data, FFh and 00h read channel A
        if (i_status_rd) begin
            st_d.rdata = (i_page == vfsr_pkg::PAGE_CH_B) ?
                         st_q.status[1] : st_q.status[0];
            st_d.imb_rd = p2_q.imb;
        end
    end

    // ==========================================================
    // State register; stored defaults kept through soft reset
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_q.status    <= '0;
            st_q.phase_a   <= vfsr_pkg::MAX_PHASES_A;
            st_q.phase_b   <= vfsr_pkg::MAX_PHASES_B;
            st_q.addr      <= vfsr_pkg::ADDR_10K;
            st_q.fsw_a     <= vfsr_pkg::FSW_DEF_A_KHZ;
            st_q.fsw_b     <= vfsr_pkg::FSW_DEF_B_KHZ;
            st_q.boot      <= 1'b1;
            st_q.ss_seen   <= 2'b00;
            st_q.rdata     <= 8'h00;
            st_q.imb_rd    <= 4'h0;
            st_q.nvm_a     <= st_d.nvm_a;
            st_q.nvm_b     <= st_d.nvm_b;
            st_q.nvm_valid <= st_d.nvm_valid;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign o_status_rdata    = st_q.rdata;
    assign o_imbalance_rdata = st_q.imb_rd;
    assign o_phase_op_a      = st_q.phase_a;
    assign o_phase_op_b      = st_q.phase_b;
    assign o_bus_addr        = st_q.addr;
    assign o_fsw_a_khz       = st_q.fsw_a;
    assign o_fsw_b_khz       = st_q.fsw_b;

endmodule

// ==== test/vfsr_chk.sv ====
`timescale 1ns/10ps
module vfsr_chk (
    // Clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_reset,
    // Status access
    input wire logic [7:0] i_page,
    input wire logic       i_status_rd,
    input wire logic [7:0] o_status_rdata,
    input wire logic [3:0] o_imbalance_rdata,
    // Conditions and configuration
    input wire logic [1:0] i_ps_fault,
    input wire logic [3:0] i_imbalance,
    input wire logic [2:0] i_phase_cfg_a,
    input wire logic [2:0] o_phase_op_a,
    input wire logic [3:0] i_addr_strap,
    input wire logic [6:0] o_bus_addr
);
    // ==========================================================
    // Status byte, address, phase count and imbalance properties
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    property p_rsv; o_status_rdata[2:1] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_hold; !i_status_rd |=> $stable(o_status_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_pgb; i_status_rd && i_page == 8'h01 |=> !o_status_rdata[3]; endproperty
    a_pgb: assert property (p_pgb) else $error("code reset bit on b");
    property p_addr; i_addr_strap == 4'h0 |-> o_bus_addr == 7'h69; endproperty
    a_addr: assert property (p_addr) else $error("bus address wrong");
    property p_clamp; $stable(i_phase_cfg_a)[*5]
        |-> o_phase_op_a == ((i_phase_cfg_a > 3'h3) ? 3'h3 : i_phase_cfg_a); endproperty
    a_clamp: assert property (p_clamp) else $error("phase count wrong");
    property p_warn; (i_phase_cfg_a > 3'h3)[*6] ##0 i_status_rd && i_page == 8'h00
        |=> o_status_rdata[5]; endproperty
    a_warn: assert property (p_warn) else $error("phase warning missing");
    property p_ps; i_ps_fault[0][*5] ##0 i_status_rd && i_page == 8'h00
        |=> o_status_rdata[7]; endproperty
    a_ps: assert property (p_ps) else $error("stage fault missing");
    property p_imb; $stable(i_imbalance)[*4] ##0 i_status_rd
        |=> o_imbalance_rdata == $past(i_imbalance); endproperty
    a_imb: assert property (p_imb) else $error("imbalance report wrong");
endmodule

// ==== test/vfsr_host.sv ====
`timescale 1ns/10ps
module vfsr_host (
    // Clock
    input  wire logic       i_clk_sys,
    // Status byte access
    output logic [7:0]      o_page = 8'h00,
    output logic            o_wr = 1'b0,
    output logic [7:0]      o_wdata = 8'h00,
    output logic            o_rd = 1'b0,
    input  wire logic [7:0] i_rdata
);
    // ==========================================================
    // Write Byte: one taken edge, data scrambled afterwards
    task automatic wr_byte(input logic [7:0] pg, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_page = pg;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk_sys);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask
    // Read Byte: data taken a cycle after the request
    task automatic rd_byte(input logic [7:0] pg, output logic [7:0] d);
        @(negedge i_clk_sys);
        o_page = pg;
        o_rd = 1'b1;
        @(negedge i_clk_sys);
        o_rd = 1'b0;
        @(negedge i_clk_sys);
        d = i_rdata;
    endtask
endmodule

// ==== test/vfsr_test.sv ====
`timescale 1ns/10ps
module vfsr_test;
    // ==========================================================
    // Stimulus and observation
    logic       i_clk_sys = 1'b0;
    logic       i_reset = 1'b1;
    logic [7:0] i_page, i_status_wdata, o_status_rdata;
    logic       i_status_wr, i_status_rd;
    logic [1:0] i_ps_fault = 2'h0, i_sense_open = 2'h2, i_temp_high = 2'h1, i_soft_start = 2'h0;
    logic       i_vcode_reset = 1'b0, i_det_tick = 1'b0, i_param_wr = 1'b0, i_store_nvm = 1'b0;
    logic [3:0] i_imbalance = 4'h0, i_addr_strap = 4'h0, o_imbalance_rdata;
    logic [2:0] i_phase_cfg_a = 3'h3, i_phase_cfg_b = 3'h1, o_phase_op_a, o_phase_op_b;
    logic [6:0] o_bus_addr;
    logic [9:0] i_fsw_a_khz = 10'h1f4, i_fsw_b_khz = 10'h258, o_fsw_a_khz, o_fsw_b_khz;
    int         miscompares = 0, checked = 0;
    always #20 i_clk_sys = ~i_clk_sys;
    vfsr_host vfsr_host_i (.i_clk_sys, .o_page(i_page), .o_wr(i_status_wr),
        .o_wdata(i_status_wdata), .o_rd(i_status_rd), .i_rdata(o_status_rdata));
    vfsr_top vfsr_top_i (.i_clk_sys, .i_reset, .i_page, .i_status_wr, .i_status_wdata,
        .i_status_rd, .o_status_rdata, .o_imbalance_rdata, .i_ps_fault, .i_sense_open,
        .i_temp_high, .i_soft_start, .i_vcode_reset, .i_det_tick, .i_imbalance,
        .i_phase_cfg_a, .i_phase_cfg_b, .o_phase_op_a, .o_phase_op_b, .i_addr_strap,
        .o_bus_addr, .i_param_wr, .i_fsw_a_khz, .i_fsw_b_khz, .i_store_nvm,
        .o_fsw_a_khz, .o_fsw_b_khz);
    // Compare and tasks
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic rdc(input logic [7:0] pg, input logic [7:0] exp);
        logic [7:0] v;
        vfsr_host_i.rd_byte(pg, v);
        chk(10'(v), 10'(exp));
    endtask
    task automatic wrb(input logic [7:0] pg, input logic [7:0] d);
        vfsr_host_i.wr_byte(pg, d);
    endtask
    task automatic tick;
        i_det_tick = 1'b1;
        cyc(1);
        i_det_tick = 1'b0;
        cyc(3);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #100us;
        miscompares++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        cyc(6);
        i_reset = 1'b0;
        cyc(2);
        chk(10'(o_bus_addr), 10'h069);
        chk(o_fsw_a_khz, 10'h190);
        chk(o_fsw_b_khz, 10'h1c2);
        cyc(4);
        i_soft_start = 2'h3;
        cyc(2);
        i_sense_open = 2'h1;
        cyc(6);
        rdc(8'h00, 8'h10);
        rdc(8'h01, 8'h40);
        rdc(8'hff, 8'h10);
        wrb(8'h01, 8'h00);
        rdc(8'h01, 8'h40);
        wrb(8'hff, 8'hff);
        rdc(8'h00, 8'h00);
        rdc(8'h01, 8'h00);
        i_ps_fault = 2'h1;
        cyc(6);
        rdc(8'h00, 8'h80);
        wrb(8'h00, 8'h86);
        rdc(8'h00, 8'h80);
        i_ps_fault = 2'h0;
        cyc(4);
        rdc(8'h01, 8'h00);
        wrb(8'h00, 8'h80);
        rdc(8'h00, 8'h00);
        i_vcode_reset = 1'b1;
        cyc(2);
        i_vcode_reset = 1'b0;
        cyc(4);
        rdc(8'h00, 8'h08);
        rdc(8'h01, 8'h00);
        i_phase_cfg_a = 3'h5;
        i_phase_cfg_b = 3'h4;
        cyc(7);
        chk(10'(o_phase_op_a), 10'h003);
        chk(10'(o_phase_op_b), 10'h001);
        rdc(8'h00, 8'h28);
        rdc(8'h01, 8'h20);
        i_phase_cfg_a = 3'h2;
        i_phase_cfg_b = 3'h1;
        cyc(6);
        chk(10'(o_phase_op_a), 10'h002);
        wrb(8'hff, 8'hff);
        i_imbalance = 4'h2;
        cyc(3);
        repeat (6) tick;
        rdc(8'h00, 8'h00);
        tick;
        cyc(4);
        rdc(8'h00, 8'h01);
        chk(10'(o_imbalance_rdata), 10'h002);
        // Channel B phase, one missing warning restarts the count
        i_imbalance = 4'h8;
        repeat (6) tick;
        i_imbalance = 4'h0;
        tick;
        i_imbalance = 4'h8;
        repeat (6) tick;
        rdc(8'h01, 8'h00);
        tick;
        cyc(4);
        rdc(8'h01, 8'h01);
        // New strap code, picked up at the next boot
        i_addr_strap = 4'h3;
        i_param_wr = 1'b1;
        cyc(1);
        i_param_wr = 1'b0;
        i_store_nvm = 1'b1;
        cyc(1);
        i_store_nvm = 1'b0;
        i_reset = 1'b1;
        cyc(6);
        i_reset = 1'b0;
        cyc(3);
        chk(o_fsw_a_khz, 10'h1f4);
        chk(o_fsw_b_khz, 10'h258);
        chk(10'(o_bus_addr), 10'h063);
        tally_and_finish;
    end
endmodule
bind vfsr_top vfsr_chk vfsr_chk_i (.i_clk_sys, .i_reset, .i_page, .i_status_rd,
    .o_status_rdata, .o_imbalance_rdata, .i_ps_fault, .i_imbalance, .i_phase_cfg_a,
    .o_phase_op_a, .i_addr_strap, .o_bus_addr);
